// ### rtl/fsgb_top.sv
// frame pulse generation and back-channel gpio slot routing, with gpio
// controls and equaliser restart on loss of lock
`timescale 1ns/1ps
module fsgb_top
    import fsgb_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // gpio pads
    input wire logic [3:0] gpio_in,
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe,
    output logic [3:0] gpio_input_on,
    output logic [3:0] gpio_pulldown_on,
    // receive link
    input wire logic [1:0] link_lock,
    output logic [1:0] eq_restart,
    output logic [1:0] lock_search,
    // back channel
    output logic [3:0] bc_slot_port0,
    output logic [3:0] bc_slot_port1,
    output logic frame_pulse
);
    // control registers
    logic [7:0] input_en;
    logic [7:0] pulldown_off;
    logic [7:0] pin_ctl [NUM_PINS];
    logic [7:0] fp_ctl;
    logic [7:0] high_upper;
    logic [7:0] high_lower;
    logic [7:0] low_upper;
    logic [7:0] low_lower;
    logic [7:0] port_sel;
    // per-port registers, driven inside the port loop
    logic [7:0] rate_sel [NUM_PORTS];
    logic [7:0] map_a [NUM_PORTS];
    logic [7:0] map_b [NUM_PORTS];
    logic [NUM_PORTS-1:0] frame_tick;
    logic [3:0] slot_level [NUM_PORTS];
    // pad and link synchronisers
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_level;
    logic [3:0] pin_used;
    logic [1:0] lock_s1;
    logic [1:0] lock_s2;
    logic [1:0] lock_s3;
    logic [1:0] lock_now;
    logic [1:0] lock_prev;
    // frame pulse path
    logic [3:0] src_sel;
    logic gen_on;
    logic gen_tick;
    logic gen_pulse;
    logic ext_mode;
    logic [15:0] high_count;
    logic [15:0] low_count;
    // register access decode
    logic [7:0] pin_idx_full;
    logic [1:0] pin_idx;
    logic pin_hit;
    logic rd_port;
    logic [7:0] next_rdata;

    // write decode for the per-pin control block
    assign pin_idx_full = reg_addr - ADDR_PIN_CTL_BASE;
    assign pin_idx = pin_idx_full[1:0];
    assign pin_hit = (pin_idx_full < 8'(NUM_PINS));
    assign rd_port = port_sel[PSEL_RD_BIT];

    // gpio input enables, all on after reset
    always_ff @(posedge clock) begin
        if (rst) begin
            input_en <= RST_INPUT_EN;
        end else if (reg_write && reg_addr == ADDR_INPUT_EN) begin
            input_en <= {4'h0, reg_wdata[3:0]};
        end
    end

    // pulldown disables, all pulldowns on after reset
    always_ff @(posedge clock) begin
        if (rst) begin
            pulldown_off <= RST_PULLDOWN;
        end else if (reg_write && reg_addr == ADDR_PULLDOWN) begin
            pulldown_off <= {4'h0, reg_wdata[3:0]};
        end
    end

    // one control register per pin; reset leaves every pin an input
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                pin_ctl[i] <= RST_ZERO;
            end
        end else if (reg_write && pin_hit) begin
            pin_ctl[pin_idx] <= reg_wdata;
        end
    end

    // frame pulse control and period registers
    always_ff @(posedge clock) begin
        if (rst) begin
            fp_ctl <= RST_ZERO;
        end else if (reg_write && reg_addr == ADDR_FP_CTL) begin
            fp_ctl <= reg_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            high_upper <= RST_ZERO;
            high_lower <= RST_ZERO;
            low_upper <= RST_ZERO;
            low_lower <= RST_ZERO;
        end else if (reg_write) begin
            if (reg_addr == ADDR_HIGH_UPPER) begin
                high_upper <= reg_wdata;
            end
            if (reg_addr == ADDR_HIGH_LOWER) begin
                high_lower <= reg_wdata;
            end
            if (reg_addr == ADDR_LOW_UPPER) begin
                low_upper <= reg_wdata;
            end
            if (reg_addr == ADDR_LOW_LOWER) begin
                low_lower <= reg_wdata;
            end
        end
    end

    // byte pairs form the two 16-bit tick counts, upper byte first
    assign high_count = {high_upper, high_lower};
    assign low_count = {low_upper, low_lower};

    // port select: low bits pick write targets, bit 4 picks readback
    always_ff @(posedge clock) begin
        if (rst) begin
            port_sel <= RST_PORT_SEL;
        end else if (reg_write && reg_addr == ADDR_PORT_SEL) begin
            port_sel <= reg_wdata;
        end
    end

    // pad inputs: three flops, a change counts once stages two and three agree
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            pin_s3 <= 4'h0;
            pin_level <= 4'h0;
        end else begin
            pin_s1 <= gpio_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_level <= (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_level);
        end
    end

    // internal users only see pins whose input path is on
    assign pin_used = pin_level & input_en[3:0];

    // lock inputs through the same three-flop filter
    always_ff @(posedge clock) begin
        if (rst) begin
            lock_s1 <= 2'h0;
            lock_s2 <= 2'h0;
            lock_s3 <= 2'h0;
            lock_now <= 2'h0;
        end else begin
            lock_s1 <= link_lock;
            lock_s2 <= lock_s1;
            lock_s3 <= lock_s2;
            lock_now <= (~(lock_s2 ^ lock_s3) & lock_s3) | ((lock_s2 ^ lock_s3) & lock_now);
        end
    end

    // equaliser reset on a lock drop; search stays up until lock is back
    always_ff @(posedge clock) begin
        if (rst) begin
            lock_prev <= 2'h0;
            eq_restart <= 2'h0;
            lock_search <= 2'h3;
        end else begin
            lock_prev <= lock_now;
            eq_restart <= lock_prev & ~lock_now;
            lock_search <= ~lock_now;
        end
    end

    // per-port registers, frame tick divider and slot routing
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        logic [7:0] rate_q;
        logic [7:0] map_a_q;
        logic [7:0] map_b_q;
        logic [6:0] tick_cnt;
        logic tick_q;
        logic [3:0] slot_q;

        // writes land on every port whose select bit is set
        always_ff @(posedge clock) begin
            if (rst) begin
                rate_q <= RST_ZERO;
                map_a_q <= RST_ZERO;
                map_b_q <= RST_ZERO;
            end else if (reg_write && port_sel[p]) begin
                if (reg_addr == ADDR_RATE_SEL) begin
                    rate_q <= reg_wdata;
                end
                if (reg_addr == ADDR_MAP_A) begin
                    map_a_q <= reg_wdata;
                end
                if (reg_addr == ADDR_MAP_B) begin
                    map_b_q <= reg_wdata;
                end
            end
        end

        // one-cycle enable per back-channel frame; other rates give no tick
        always_ff @(posedge clock) begin
            if (rst || rate_q[2:0] != RATE_2M5) begin
                tick_cnt <= 7'h00;
                tick_q <= 1'b0;
            end else if (tick_cnt == TICK_LAST) begin
                tick_cnt <= 7'h00;
                tick_q <= 1'b1;
            end else begin
                tick_cnt <= tick_cnt + 7'h01;
                tick_q <= 1'b0;
            end
        end

        // each slot picks a pin, the frame pulse, or a quiet zero
        for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
            logic [3:0] field;
            assign field = (s < 2) ? map_a_q[4*(s%2) +: 4] : map_b_q[4*(s%2) +: 4];
            always_ff @(posedge clock) begin
                if (rst) begin
                    slot_q[s] <= 1'b0;
                end else if (field <= SLOT_PIN_LAST) begin
                    slot_q[s] <= pin_used[field[1:0]];
                end else if (field == SLOT_SRC_FRAME) begin
                    slot_q[s] <= frame_pulse;
                end else begin
                    slot_q[s] <= 1'b0;
                end
            end
        end

        assign rate_sel[p] = rate_q;
        assign map_a[p] = map_a_q;
        assign map_b[p] = map_b_q;
        assign frame_tick[p] = tick_q;
        assign slot_level[p] = slot_q;
    end

    assign bc_slot_port0 = slot_level[0];
    assign bc_slot_port1 = slot_level[1];

    // tick source and external pin choice from the source field
    assign src_sel = fp_ctl[FPC_SRC_LSB +: 4];
    assign gen_on = fp_ctl[FPC_GEN_ON_BIT];
    assign ext_mode = (src_sel >= SRC_PIN_FIRST) && (src_sel <= SRC_PIN_LAST);

    always_comb begin
        if (src_sel == SRC_PORT0) begin
            gen_tick = frame_tick[0];
        end else if (src_sel == SRC_PORT1) begin
            gen_tick = frame_tick[1];
        end else begin
            gen_tick = 1'b0;
        end
    end

    fsgb_pulse_gen u_gen (
        .clock(clock),
        .rst(rst),
        .gen_on(gen_on),
        .tick(gen_tick),
        .duty_style(fp_ctl[FPC_DUTY_BIT]),
        .start_level(fp_ctl[FPC_START_BIT]),
        .high_count(high_count),
        .low_count(low_count),
        .pulse(gen_pulse)
    );

    // generator wins; external pin mode needs the generator left off
    always_ff @(posedge clock) begin
        if (rst) begin
            frame_pulse <= 1'b0;
        end else if (gen_on) begin
            frame_pulse <= gen_pulse;
        end else if (ext_mode) begin
            frame_pulse <= pin_used[src_sel[1:0]];
        end else begin
            frame_pulse <= 1'b0;
        end
    end

    // pin drivers: register level or the frame pulse when enabled
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        always_ff @(posedge clock) begin
            if (rst) begin
                gpio_oe[i] <= 1'b0;
                gpio_out[i] <= 1'b0;
            end else begin
                gpio_oe[i] <= pin_ctl[i][PIN_OE_BIT];
                gpio_out[i] <= pin_ctl[i][PIN_FP_BIT] ? frame_pulse
                                                     : pin_ctl[i][PIN_LEVEL_BIT];
            end
        end
    end

    // pad controls follow their registers
    assign gpio_input_on = input_en[3:0];
    assign gpio_pulldown_on = ~pulldown_off[3:0];

    // read mux; per-port registers follow the readback port bit
    always_comb begin
        next_rdata = 8'h00;
        if (pin_hit) begin
            next_rdata = pin_ctl[pin_idx];
        end else begin
            unique case (reg_addr)
                ADDR_PIN_LEVEL: next_rdata = {4'h0, pin_level};
                ADDR_INPUT_EN: next_rdata = input_en;
                ADDR_PULLDOWN: next_rdata = pulldown_off;
                ADDR_FP_CTL: next_rdata = fp_ctl;
                ADDR_HIGH_UPPER: next_rdata = high_upper;
                ADDR_HIGH_LOWER: next_rdata = high_lower;
                ADDR_LOW_UPPER: next_rdata = low_upper;
                ADDR_LOW_LOWER: next_rdata = low_lower;
                ADDR_PORT_SEL: next_rdata = port_sel;
                ADDR_RATE_SEL: next_rdata = rate_sel[rd_port];
                ADDR_MAP_A: next_rdata = map_a[rd_port];
                ADDR_MAP_B: next_rdata = map_b[rd_port];
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_read) begin
                reg_rdata <= next_rdata;
            end
        end
    end
endmodule

// ### rtl/fsgb_pkg.sv
// shared constants and types for the frame pulse back-channel gpio block
package fsgb_pkg;
    // structure
    localparam int NUM_PINS = 4;
    localparam int NUM_PORTS = 2;
    localparam int NUM_SLOTS = 4;
    localparam int SLOT_FIELD_W = 4;
    // register offsets
    localparam logic [7:0] ADDR_PIN_LEVEL = 8'h0E;
    localparam logic [7:0] ADDR_INPUT_EN = 8'h0F;
    localparam logic [7:0] ADDR_PIN_CTL_BASE = 8'h10;
    localparam logic [7:0] ADDR_FP_CTL = 8'h18;
    localparam logic [7:0] ADDR_HIGH_UPPER = 8'h19;
    localparam logic [7:0] ADDR_HIGH_LOWER = 8'h1A;
    localparam logic [7:0] ADDR_LOW_UPPER = 8'h1B;
    localparam logic [7:0] ADDR_LOW_LOWER = 8'h1C;
    localparam logic [7:0] ADDR_PORT_SEL = 8'h4C;
    localparam logic [7:0] ADDR_RATE_SEL = 8'h58;
    localparam logic [7:0] ADDR_MAP_A = 8'h6E;
    localparam logic [7:0] ADDR_MAP_B = 8'h6F;
    localparam logic [7:0] ADDR_PULLDOWN = 8'hBE;
    // reset values
    localparam logic [7:0] RST_INPUT_EN = 8'h0F;
    localparam logic [7:0] RST_PULLDOWN = 8'h00;
    localparam logic [7:0] RST_PORT_SEL = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // frame_pulse_control fields
    localparam int FPC_GEN_ON_BIT = 0;
    localparam int FPC_DUTY_BIT = 1;
    localparam int FPC_START_BIT = 2;
    localparam int FPC_SRC_LSB = 4;
    localparam logic [3:0] SRC_PORT0 = 4'h0;
    localparam logic [3:0] SRC_PORT1 = 4'h1;
    localparam logic [3:0] SRC_PIN_FIRST = 4'h8;
    localparam logic [3:0] SRC_PIN_LAST = 4'hB;
    // per-pin control fields
    localparam int PIN_OE_BIT = 0;
    localparam int PIN_LEVEL_BIT = 1;
    localparam int PIN_FP_BIT = 2;
    // port select fields
    localparam int PSEL_RD_BIT = 4;
    // slot map and rate fields
    localparam logic [3:0] SLOT_PIN_LAST = 4'h3;
    localparam logic [3:0] SLOT_SRC_FRAME = 4'hA;
    localparam logic [2:0] RATE_2M5 = 3'h0;
    // timing: one back-channel frame is 30 bits of 400 ns
    localparam int CLK_PERIOD_NS = 100;
    localparam int BC_BIT_NS = 400;
    localparam int BC_FRAME_BITS = 30;
    localparam int BC_FRAME_CYCLES = (BC_BIT_NS * BC_FRAME_BITS) / CLK_PERIOD_NS;
    localparam logic [6:0] TICK_LAST = 7'(BC_FRAME_CYCLES - 1);
    // generator states
    typedef enum logic [2:0] {
        GEN_IDLE = 3'b001,
        GEN_HIGH = 3'b010,
        GEN_LOW = 3'b100
    } fsgb_gen_state_t;
endpackage

// ### rtl/fsgb_pulse_gen.sv
// internal frame pulse generator counting back-channel frame ticks
`timescale 1ns/1ps
module fsgb_pulse_gen
    import fsgb_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic gen_on,
    input wire logic tick,
    input wire logic duty_style,
    input wire logic start_level,
    input wire logic [15:0] high_count,
    input wire logic [15:0] low_count,
    // generated level
    output logic pulse
);
    fsgb_gen_state_t state;
    logic [15:0] remain;
    logic [16:0] period_sum;
    logic [15:0] half_count;
    logic [15:0] high_len;
    logic [15:0] low_len;

    // even duty gives each half the programmed period halved, an odd tick dropped
    assign period_sum = {1'b0, high_count} + {1'b0, low_count};
    assign half_count = period_sum[16:1];
    assign high_len = duty_style ? half_count : high_count;
    assign low_len = duty_style ? half_count : low_count;

    // disable parks the generator; a zero count acts as one tick
    always_ff @(posedge clock) begin
        if (rst || !gen_on) begin
            state <= GEN_IDLE;
            remain <= 16'h0000;
        end else begin
            unique case (state)
                GEN_IDLE: begin
                    state <= start_level ? GEN_HIGH : GEN_LOW;
                    remain <= start_level ? high_len : low_len;
                end
                GEN_HIGH: begin
                    if (tick && remain <= 16'h0001) begin
                        state <= GEN_LOW;
                        remain <= low_len;
                    end else if (tick) begin
                        remain <= remain - 16'h0001;
                    end
                end
                GEN_LOW: begin
                    if (tick && remain <= 16'h0001) begin
                        state <= GEN_HIGH;
                        remain <= high_len;
                    end else if (tick) begin
                        remain <= remain - 16'h0001;
                    end
                end
            endcase
        end
    end

    // level straight from the state flop
    assign pulse = (state == GEN_HIGH);
endmodule

// ### test/fsgb_asserts.sv
// port-level checks for the frame pulse back-channel gpio block
`timescale 1ns/1ps
module fsgb_asserts
    import fsgb_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // pads and link
    input wire logic [3:0] gpio_in,
    input wire logic [3:0] gpio_oe,
    input wire logic [3:0] gpio_input_on,
    input wire logic [3:0] gpio_pulldown_on,
    input wire logic [1:0] link_lock,
    input wire logic [1:0] eq_restart,
    input wire logic [1:0] lock_search,
    input wire logic frame_pulse
);
    logic [7:0] ctl_seen;
    logic oe0_want;
    // shadows rebuilt from bus writes, since the checker cannot see registers
    always_ff @(posedge clock) begin
        if (rst) begin
            ctl_seen <= 8'h00;
            oe0_want <= 1'b0;
        end else if (reg_write) begin
            if (reg_addr == ADDR_FP_CTL) ctl_seen <= reg_wdata;
            if (reg_addr == ADDR_PIN_CTL_BASE) oe0_want <= reg_wdata[0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_rvalid;
        reg_read |=> reg_rvalid;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_pin_level;
        $stable(gpio_in)[*5] ##0 (reg_read && reg_addr == ADDR_PIN_LEVEL)
            |=> reg_rdata[3:0] == $past(gpio_in);
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin level wrong");
    property p_input_on;
        reg_write && reg_addr == ADDR_INPUT_EN
            |=> {4'h0, gpio_input_on} == ($past(reg_wdata) & 8'h0F);
    endproperty
    a_input_on: assert property (p_input_on) else $error("input enable wrong");
    property p_pulldown;
        reg_write && reg_addr == ADDR_PULLDOWN
            |=> {4'h0, gpio_pulldown_on} == (~$past(reg_wdata) & 8'h0F);
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pulldown wrong");
    property p_pin_oe;
        (reg_write && reg_addr == ADDR_PIN_CTL_BASE)
            ##1 !(reg_write && reg_addr == ADDR_PIN_CTL_BASE)[*2] |-> gpio_oe[0] == oe0_want;
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");
    property p_eq_restart;
        $fell(link_lock[0]) |-> ##[3:6] (eq_restart[0] && lock_search[0]);
    endproperty
    a_eq_restart: assert property (p_eq_restart) else $error("no restart");
    property p_eq_pulse;
        eq_restart[0] |=> !eq_restart[0];
    endproperty
    a_eq_pulse: assert property (p_eq_pulse) else $error("restart too long");
    property p_search_end;
        link_lock[0] [*8] |-> !lock_search[0];
    endproperty
    a_search_end: assert property (p_search_end) else $error("search stuck");
    property p_pulse_source;
        $rose(frame_pulse) |-> $past(ctl_seen[0])
            || ($past(ctl_seen[7:4]) >= SRC_PIN_FIRST && $past(ctl_seen[7:4]) <= SRC_PIN_LAST);
    endproperty
    a_pulse_source: assert property (p_pulse_source) else $error("stray pulse");
endmodule

// ### test/fsgb_remote_model.sv
// remote serializer stand-in: holds lock, counts pulses on port 0 slot 0
`timescale 1ns/1ps
module fsgb_remote_model (
    // clock and scenario command
    input wire logic clock,
    input wire logic [1:0] lose_lock,
    // back channel as received remotely
    input wire logic [3:0] bc_slot_port0,
    // lock toward the receiver and pulse count
    output logic [1:0] link_lock,
    output logic [7:0] slot0_rises
);
    logic prev0;
    initial begin
        link_lock = 2'h3;
        slot0_rises = 8'h00;
        prev0 = 1'b0;
    end
    // lock drops only on command, changed away from the receiving edge
    always @(negedge clock) begin
        link_lock <= ~lose_lock;
    end
    // each rising slot level counts as one delivered frame pulse
    always @(posedge clock) begin
        if (bc_slot_port0[0] && !prev0) slot0_rises <= slot0_rises + 8'h01;
        prev0 <= bc_slot_port0[0];
    end
endmodule

// ### test/fsgb_tb_top.sv
// self-checking bench for the frame pulse back-channel gpio block
`timescale 1ns/1ps
module fsgb_tb_top
    import fsgb_pkg::*;
;
    logic clock, rst, reg_write, reg_read, reg_rvalid, frame_pulse, v;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rises, r0;
    logic [3:0] gpio_in, gpio_out, gpio_oe, gpio_input_on, gpio_pulldown_on, pad_drv, p;
    logic [3:0] bc_slot_port0, bc_slot_port1;
    logic [1:0] link_lock, eq_restart, lock_search, lose_lock;
    int mismatches, total_checks, len, k;
    // pad level: the design wins where it drives, else the board
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & pad_drv);
    fsgb_top fsgb_top_i (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .gpio_input_on(gpio_input_on), .gpio_pulldown_on(gpio_pulldown_on),
        .link_lock(link_lock), .eq_restart(eq_restart), .lock_search(lock_search),
        .bc_slot_port0(bc_slot_port0), .bc_slot_port1(bc_slot_port1),
        .frame_pulse(frame_pulse));
    fsgb_remote_model fsgb_remote_model_i (.clock(clock), .lose_lock(lose_lock),
        .bc_slot_port0(bc_slot_port0), .link_lock(link_lock), .slot0_rises(rises));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        check({7'h0, reg_rvalid}, 8'h01);
        check(reg_rdata, exp);
    endtask
    // waits for the level, then counts how long it holds; both bounded
    task automatic run_len(input logic lvl, output int n);
        int w;
        w = 0;
        n = 0;
        while (frame_pulse !== lvl && w < 2000) begin
            @(negedge clock);
            w++;
        end
        while (frame_pulse === lvl && n < 2000) begin
            @(negedge clock);
            n++;
        end
        if (w >= 2000 || n >= 2000) begin
            mismatches++;
            give_verdict();
        end
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        give_verdict();
    end
    initial begin
        mismatches = 0;
        total_checks = 0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        pad_drv = 4'h0;
        lose_lock = 2'h0;
        repeat (5) @(negedge clock);
        rst = 1'b0;
        check({4'h0, gpio_input_on}, 8'h0F);
        check({4'h0, gpio_pulldown_on}, 8'h0F);
        rd(ADDR_INPUT_EN, RST_INPUT_EN);
        rd(ADDR_PULLDOWN, RST_PULLDOWN);
        rd(8'hF0, 8'h00);
        wr(ADDR_INPUT_EN, 8'hF5);
        wr(ADDR_PULLDOWN, 8'h0A);
        check({4'h0, gpio_input_on}, 8'h05);
        check({4'h0, gpio_pulldown_on}, 8'h05);
        rd(ADDR_INPUT_EN, 8'h05);
        wr(ADDR_INPUT_EN, 8'h0F);
        $display("test gpio controls done");
        // pin 0 driven high by the design, the rest from the board
        pad_drv = 4'hA;
        wr(ADDR_PIN_CTL_BASE, 8'h03);
        repeat (6) @(negedge clock);
        check({4'h0, gpio_oe}, 8'h01);
        rd(ADDR_PIN_LEVEL, 8'h0B);
        wr(ADDR_PIN_CTL_BASE, 8'h00);
        $display("test pin level done");
        // pin 2 feeds two slots on both ports at once
        wr(ADDR_PORT_SEL, 8'h03);
        wr(ADDR_MAP_A, 8'h12);
        wr(ADDR_MAP_B, 8'h32);
        for (int i = 0; i < 2; i++) begin
            p = (i == 0) ? 4'h6 : 4'h9;
            pad_drv = p;
            repeat (8) @(negedge clock);
            check({4'h0, bc_slot_port0}, {4'h0, p[3], p[2], p[1], p[2]});
            check({4'h0, bc_slot_port1}, {4'h0, p[3], p[2], p[1], p[2]});
        end
        $display("test slot routing done");
        // external pulse from pin 1 on port 0 slot 0 only
        pad_drv = 4'h0;
        wr(ADDR_PORT_SEL, 8'h02);
        wr(ADDR_MAP_A, 8'h10);
        wr(ADDR_PORT_SEL, 8'h01);
        wr(ADDR_MAP_A, 8'h1A);
        wr(ADDR_FP_CTL, 8'h90);
        repeat (8) @(negedge clock);
        r0 = rises;
        for (int i = 0; i < 3; i++) begin
            pad_drv = 4'h2;
            repeat (12) @(negedge clock);
            check({7'h0, frame_pulse}, 8'h01);
            check({4'h0, bc_slot_port1}, 8'h02);
            pad_drv = 4'h0;
            repeat (12) @(negedge clock);
        end
        check(rises - r0, 8'h03);
        wr(ADDR_FP_CTL, 8'h00);
        $display("test external pulse done");
        // internal generator: high 2 ticks, low 3 ticks, tick 120 cycles
        wr(ADDR_RATE_SEL, 8'h00);
        wr(ADDR_HIGH_UPPER, 8'h00);
        wr(ADDR_HIGH_LOWER, 8'h02);
        wr(ADDR_LOW_UPPER, 8'h00);
        wr(ADDR_LOW_LOWER, 8'h03);
        wr(ADDR_FP_CTL, 8'h01);
        run_len(1'b1, len);
        check(8'(len), 8'hF0);
        run_len(1'b0, len);
        check(8'(len / 120), 8'h03);
        check(8'(len % 120), 8'h00);
        run_len(1'b1, len);
        check(8'(len), 8'hF0);
        // 50/50: both halves take (2 + 3) / 2 ticks
        wr(ADDR_FP_CTL, 8'h03);
        run_len(1'b1, len);
        run_len(1'b0, len);
        check(8'(len), 8'hF0);
        run_len(1'b1, len);
        check(8'(len), 8'hF0);
        // another rate stops the tick, so the level freezes
        wr(ADDR_RATE_SEL, 8'h01);
        // a tick already in flight may still move the level once
        repeat (3) @(negedge clock);
        v = frame_pulse;
        repeat (400) @(negedge clock);
        check({7'h0, frame_pulse}, {7'h0, v});
        wr(ADDR_FP_CTL, 8'h00);
        wr(ADDR_RATE_SEL, 8'h00);
        repeat (300) @(negedge clock);
        check({7'h0, frame_pulse}, 8'h00);
        wr(ADDR_FP_CTL, 8'h05);
        wr(ADDR_PIN_CTL_BASE + 8'h01, 8'h05);
        repeat (4) @(negedge clock);
        check({4'h0, gpio_out}, 8'h02);
        check({7'h0, frame_pulse}, 8'h01);
        check({7'h0, bc_slot_port0[0]}, 8'h01);
        wr(ADDR_FP_CTL, 8'h00);
        $display("test internal generator done");
        // lock loss on port 0 only
        lose_lock = 2'h1;
        k = 0;
        while (eq_restart[0] !== 1'b1 && k < 20) begin
            @(negedge clock);
            k++;
        end
        check({6'h0, eq_restart}, 8'h01);
        @(negedge clock);
        check({6'h0, eq_restart}, 8'h00);
        repeat (20) @(negedge clock);
        check({6'h0, lock_search}, 8'h01);
        lose_lock = 2'h0;
        repeat (10) @(negedge clock);
        check({6'h0, lock_search}, 8'h00);
        $display("test lock loss done");
        give_verdict();
    end
endmodule
bind fsgb_top fsgb_asserts fsgb_asserts_i (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .gpio_in(gpio_in), .gpio_oe(gpio_oe),
    .gpio_input_on(gpio_input_on), .gpio_pulldown_on(gpio_pulldown_on),
    .link_lock(link_lock), .eq_restart(eq_restart), .lock_search(lock_search),
    .frame_pulse(frame_pulse));
